/* File: hdl/vft_pkg.sv */
package vft_pkg;

    // Register offsets. The total and active register sits just below the blank window.
    localparam logic [15:0] VFT_OFS_TOTAL_ACTIVE = 16'h8340;
    localparam logic [15:0] VFT_OFS_BLANK_WIN    = 16'h8344;
    localparam logic [15:0] VFT_OFS_CRT_SYNC_WIN = 16'h8348;
    localparam logic [15:0] VFT_OFS_PANEL_SYNC   = 16'h834C;
    localparam logic [15:0] VFT_OFS_LINE_COUNT   = 16'h8354;
    localparam logic [15:0] VFT_OFS_CONTROL      = 16'h8360;

    // Field layout shared by all window registers.
    localparam int VFT_LO_MSB = 10;
    localparam int VFT_HI_LSB = 16;
    localparam int VFT_HI_MSB = 26;
    localparam int VFT_LW     = 11;
    localparam int VFT_CTL_INTERLACE = 0;
    localparam int VFT_CTL_ENABLE    = 1;

    localparam logic [10:0] VFT_LINE_ZERO = 11'h000;
    localparam logic [10:0] VFT_LINE_ONE  = 11'h001;
    localparam logic [31:0] VFT_WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] VFT_WIN_MASK  = 32'h07FF_07FF;
    localparam logic [31:0] VFT_CTL_MASK  = 32'h0000_0003;

    // Register bus request.
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } vft_bus_req_t;

    // Low and high line values of one window register.
    typedef struct packed {
        logic [10:0] hi;
        logic [10:0] lo;
    } vft_win_t;

    // Display outputs.
    typedef struct packed {
        logic vblank;
        logic crt_vsync;
        logic panel_vsync;
        logic frame_start;
    } vft_disp_t;

endpackage : vft_pkg

/* File: hdl/vft_line_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module vft_line_counter
    import vft_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Control.
    input  wire logic        run,
    input  wire logic        interlace,
    input  wire logic        line_strobe,
    input  wire logic        half_strobe,
    input  wire logic [10:0] total,
    // Count.
    output logic [10:0]      count,
    output logic             frame_end
);

    typedef struct packed {
        logic [10:0] cnt;
        logic        fend;
    } vft_cnt_state_t;

    vft_cnt_state_t s_q;
    vft_cnt_state_t s_d;
    logic           step;

    always_comb begin
        s_d  = s_q;
        // Interlaced mode counts on the line strobe and the mid-line strobe. [R11] [R15]
        step = line_strobe | (interlace & half_strobe);
        s_d.fend = 1'b0;
        if (!run) begin
            s_d.cnt = VFT_LINE_ZERO;
        end else if (step) begin
            // Frame ends after total plus one counts. [R1] [R15]
            if (s_q.cnt >= total) begin
                s_d.cnt  = VFT_LINE_ZERO;
                s_d.fend = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + VFT_LINE_ONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign count     = s_q.cnt;
    assign frame_end = s_q.fend;

endmodule : vft_line_counter
`default_nettype wire

/* File: hdl/vft_window.sv */
`timescale 1ns/1ps
`default_nettype none
module vft_window
    import vft_pkg::*;
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // Compare.
    input  wire logic        run,
    input  wire logic        step,
    input  wire logic [10:0] count,
    input  wire vft_win_t    win,
    // Result.
    output logic             level
);

    typedef struct packed {
        logic lvl;
    } vft_win_state_t;

    vft_win_state_t s_q;
    vft_win_state_t s_d;

    // The output changes on the counter step taken while the count equals the programmed value.
    always_comb begin
        s_d = s_q;
        if (!run) begin
            s_d.lvl = 1'b0;
        end else if (step) begin
            if (count == win.lo) begin
                s_d.lvl = 1'b1;
            end else if (count == win.hi) begin
                s_d.lvl = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign level = s_q.lvl;

endmodule : vft_window
`default_nettype wire

/* File: hdl/vft_vertical_timing.sv */
// Contract
// [R1] Frame lasts the programmed total plus one lines, then restarts.
// [R2] Software programs an even total when interlaced, giving an odd line count.
// [R3] Lines past the active count are border or blanked lines.
// [R4] Software shifts blank and sync values by half the panel shortfall to centre.
// [R5] Software programs an even active line count when interlaced.
// [R6] Blank output drops at the programmed end line.
// [R7] Blank output rises at the programmed start line.
// [R8] Interlaced blanking spans from active count to total, with no border.
// [R9] CRT vertical sync drops at its programmed end line.
// [R10] CRT vertical sync rises at its programmed start line.
// [R11] Interlaced counter advances twice per line, so sync may start mid-line.
// [R12] Panel sync ends at its programmed value, offset by two lines; the code applies no offset to the end value.
// [R13] Internal panel sync passes a latch stage before reaching the panel.
// [R14] Panel sync start compares against the counter like the end value.
// [R15] Counter clears at frame end, advances per line strobe or twice when interlaced.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module vft_vertical_timing
    import vft_pkg::*;
(
    // Clock and reset.
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          clk_en,
    // Register port.
    input  wire vft_bus_req_t  bus_req,
    output logic [31:0]        rdata,
    // Horizontal timing strobes.
    input  wire logic          line_strobe,
    input  wire logic          half_strobe,
    // Display outputs.
    output vft_disp_t          disp,
    output logic [10:0]        line_count
);

    typedef struct packed {
        logic [31:0] tot_act;
        logic [31:0] blank_win;
        logic [31:0] crt_win;
        logic [31:0] panel_win;
        logic [1:0]  ctl;
        logic [31:0] rdata;
        logic        panel_out;
        vft_disp_t   disp;
        logic [10:0] line;
    } vft_top_state_t;

    vft_top_state_t s_q;
    vft_top_state_t s_d;

    logic        run;
    logic        ilace;
    logic        step;
    logic [10:0] count;
    logic        frame_end;
    logic        blank_lvl;
    logic        crt_lvl;
    logic        panel_lvl;
    vft_win_t    blank_w;
    vft_win_t    crt_w;
    vft_win_t    panel_w;

    function automatic vft_win_t vft_split(input logic [31:0] r);
        vft_win_t w;
        w.hi = r[VFT_HI_MSB:VFT_HI_LSB];
        w.lo = r[VFT_LO_MSB:0];
        return w;
    endfunction : vft_split

    assign run   = s_q.ctl[VFT_CTL_ENABLE];
    assign ilace = s_q.ctl[VFT_CTL_INTERLACE];
    assign step  = line_strobe | (ilace & half_strobe);

    always_comb begin
        // Interlaced blanking follows active and total directly. [R8] [R3]
        if (ilace) begin
            blank_w.lo = s_q.tot_act[VFT_LO_MSB:0];
            blank_w.hi = s_q.tot_act[VFT_HI_MSB:VFT_HI_LSB];
        end else begin
            blank_w = vft_split(s_q.blank_win);
        end
    end

    assign crt_w   = vft_split(s_q.crt_win);
    assign panel_w = vft_split(s_q.panel_win);

    vft_line_counter u_cnt (
        .core_clk    (core_clk),
        .rst         (rst),
        .clk_en      (clk_en),
        .run         (run),
        .interlace   (ilace),
        .line_strobe (line_strobe),
        .half_strobe (half_strobe),
        .total       (s_q.tot_act[VFT_HI_MSB:VFT_HI_LSB]),
        .count       (count),
        .frame_end   (frame_end)
    );

    // Blank rises at start value and falls at end value. [R6] [R7]
    vft_window u_blank (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .run      (run),
        .step     (step),
        .count    (count),
        .win      (blank_w),
        .level    (blank_lvl)
    );

    // CRT sync follows its window on every count, including mid-line ones. [R9] [R10] [R11]
    vft_window u_crt (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .run      (run),
        .step     (step),
        .count    (count),
        .win      (crt_w),
        .level    (crt_lvl)
    );

    // Internal panel sync uses the same compare for start and end. [R14] [R12]
    vft_window u_panel (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .run      (run),
        .step     (step),
        .count    (count),
        .win      (panel_w),
        .level    (panel_lvl)
    );

    always_comb begin
        s_d = s_q;
        s_d.rdata = VFT_WORD_ZERO;
        if (bus_req.wr) begin
            case (bus_req.addr)
                VFT_OFS_TOTAL_ACTIVE: s_d.tot_act   = bus_req.wdata & VFT_WIN_MASK;
                VFT_OFS_BLANK_WIN:    s_d.blank_win = bus_req.wdata & VFT_WIN_MASK;
                VFT_OFS_CRT_SYNC_WIN: s_d.crt_win   = bus_req.wdata & VFT_WIN_MASK;
                VFT_OFS_PANEL_SYNC:   s_d.panel_win = bus_req.wdata & VFT_WIN_MASK;
                VFT_OFS_CONTROL:      s_d.ctl       = bus_req.wdata[1:0];
                default: ;
            endcase
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                VFT_OFS_TOTAL_ACTIVE: s_d.rdata = s_q.tot_act;
                VFT_OFS_BLANK_WIN:    s_d.rdata = s_q.blank_win;
                VFT_OFS_CRT_SYNC_WIN: s_d.rdata = s_q.crt_win;
                VFT_OFS_PANEL_SYNC:   s_d.rdata = s_q.panel_win;
                VFT_OFS_LINE_COUNT:   s_d.rdata = {21'h0, count};
                VFT_OFS_CONTROL:      s_d.rdata = {30'h0, s_q.ctl};
                default:              s_d.rdata = VFT_WORD_ZERO;
            endcase
        end
        // Panel sync passes one latch stage before the output register. [R13]
        s_d.panel_out        = panel_lvl;
        s_d.disp.panel_vsync = s_q.panel_out;
        s_d.disp.vblank      = blank_lvl;
        s_d.disp.crt_vsync   = crt_lvl;
        s_d.disp.frame_start = frame_end;
        s_d.line             = count;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign rdata      = s_q.rdata;
    assign disp       = s_q.disp;
    assign line_count = s_q.line;

endmodule : vft_vertical_timing
`default_nettype wire

/* File: tb/vft_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module vft_checker
    import vft_pkg::*;
(
    // Clock and reset.
    input wire logic         core_clk,
    input wire logic         rst,
    input wire logic         clk_en,
    // Register port.
    input wire vft_bus_req_t bus_req,
    input wire logic [31:0]  rdata,
    // Strobes and outputs.
    input wire logic         line_strobe,
    input wire logic         half_strobe,
    input wire vft_disp_t    disp,
    input wire logic [10:0]  line_count
);
    logic [31:0] ta_q, bw_q, cw_q, pw_q, ct_q;
    logic        il, step;
    // Shadow copies of the registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {ta_q, bw_q, cw_q, pw_q, ct_q} <= '0;
        end else if (clk_en && bus_req.wr) begin
            case (bus_req.addr)
                VFT_OFS_TOTAL_ACTIVE: ta_q <= bus_req.wdata;
                VFT_OFS_BLANK_WIN:    bw_q <= bus_req.wdata;
                VFT_OFS_CRT_SYNC_WIN: cw_q <= bus_req.wdata;
                VFT_OFS_PANEL_SYNC:   pw_q <= bus_req.wdata;
                VFT_OFS_CONTROL:      ct_q <= bus_req.wdata;
                default:              ;
            endcase
        end
    end
    assign il = ct_q[VFT_CTL_INTERLACE];
    assign step = clk_en && ct_q[VFT_CTL_ENABLE] && (line_strobe || (il && half_strobe));
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_at(logic [10:0] v);
        step && line_count == v;
    endsequence
    property p_blank_rise;
        s_at(bw_q[10:0]) ##0 !il |-> ##[1:3] disp.vblank;
    endproperty
    a_blank_rise: assert property (p_blank_rise) else $error("vblank late");
    property p_blank_fall;
        s_at(bw_q[26:16]) ##0 (!il && bw_q[26:16] != bw_q[10:0]) |-> ##[1:3] !disp.vblank;
    endproperty
    a_blank_fall: assert property (p_blank_fall) else $error("vblank stuck");
    property p_crt_rise;
        s_at(cw_q[10:0]) |-> ##[1:3] disp.crt_vsync;
    endproperty
    a_crt_rise: assert property (p_crt_rise) else $error("vsync late");
    property p_crt_fall;
        s_at(cw_q[26:16]) ##0 (cw_q[26:16] != cw_q[10:0]) |-> ##[1:3] !disp.crt_vsync;
    endproperty
    a_crt_fall: assert property (p_crt_fall) else $error("vsync stuck");
    property p_panel_lag;
        $rose(disp.crt_vsync) ##0 (pw_q == cw_q) |=> $rose(disp.panel_vsync);
    endproperty
    a_panel_lag: assert property (p_panel_lag) else $error("panel lag");
    property p_il_blank;
        s_at(ta_q[10:0]) ##0 il |-> ##[1:3] disp.vblank;
    endproperty
    a_il_blank: assert property (p_il_blank) else $error("il blank");
    property p_wrap;
        step && line_count >= ta_q[26:16] |-> ##[1:3] disp.frame_start;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_advance;
        step && line_count < ta_q[26:16] |-> ##2 line_count == $past(line_count, 2) + VFT_LINE_ONE;
    endproperty
    a_advance: assert property (p_advance) else $error("no step");
endmodule : vft_checker
`default_nettype wire

/* File: tb/vft_display_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vft_display_model
    import vft_pkg::*;
(
    // Clock and reset.
    input wire logic   core_clk,
    input wire logic   rst,
    // Observed lines.
    input wire logic   interlace,
    input wire logic   line_strobe,
    input wire logic   half_strobe,
    input wire vft_disp_t disp,
    // Measured frame.
    output logic [10:0] frame_steps,
    output logic [10:0] blank_steps
);
    logic [10:0] n_q, b_q;
    logic        step;
    // A step is one counter advance of the timing source.
    assign step = line_strobe || (interlace && half_strobe);
    always_ff @(posedge core_clk) begin
        if (disp.frame_start) begin
            frame_steps <= n_q;
            blank_steps <= b_q;
        end
        if (rst) begin
            n_q <= '0;
            b_q <= '0;
        end else if (disp.frame_start) begin
            // A step may fall on the same edge as the frame marker; it opens the new frame.
            n_q <= {10'h0, step};
            b_q <= {10'h0, step && disp.vblank};
        end else if (step) begin
            n_q <= n_q + VFT_LINE_ONE;
            b_q <= b_q + {10'h0, disp.vblank};
        end
    end
endmodule : vft_display_model
`default_nettype wire

/* File: tb/vft_vertical_timing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module vft_vertical_timing_tb
    import vft_pkg::*;
;
    logic         core_clk, rst, clk_en, line_strobe, half_strobe, interlace;
    vft_bus_req_t bus_req;
    logic [31:0]  rdata;
    vft_disp_t    disp;
    logic [10:0]  line_count, spf, bsteps;
    int           fail_count, samples_checked;
    // Centering shift of one line in both fields.
    localparam logic [31:0] SHIFT = 32'h0001_0001;
    vft_vertical_timing vft_vertical_timing_i (.core_clk(core_clk), .rst(rst),
        .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata), .line_strobe(line_strobe),
        .half_strobe(half_strobe), .disp(disp), .line_count(line_count));
    vft_display_model vft_display_model_i (.core_clk(core_clk), .rst(rst),
        .interlace(interlace), .line_strobe(line_strobe), .half_strobe(half_strobe),
        .disp(disp), .frame_steps(spf), .blank_steps(bsteps));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [15:0] a, logic [31:0] e);
        @(posedge core_clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        @(negedge core_clk);
        check("rdata", rdata, e);
    endtask : rd
    task automatic lines(int n, bit il);
        repeat (n) begin
            @(posedge core_clk);
            line_strobe <= 1'b1;
            @(posedge core_clk);
            line_strobe <= 1'b0;
            @(posedge core_clk);
            if (il) begin
                half_strobe <= 1'b1;
                @(posedge core_clk);
                half_strobe <= 1'b0;
                @(posedge core_clk);
            end
        end
    endtask : lines
    task automatic t_regs();
        rd(VFT_OFS_BLANK_WIN, VFT_WORD_ZERO);
        wr(VFT_OFS_BLANK_WIN, 32'hFFFF_FFFF);
        rd(VFT_OFS_BLANK_WIN, VFT_WIN_MASK);
        // A write while the clock enable is low must leave the register untouched.
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(VFT_OFS_BLANK_WIN, VFT_WORD_ZERO);
        clk_en <= 1'b1;
        rd(VFT_OFS_BLANK_WIN, VFT_WIN_MASK);
        wr(VFT_OFS_CONTROL, 32'hFFFF_FFFD);
        rd(VFT_OFS_CONTROL, 32'h0000_0001);
        wr(16'h8380, 32'hFFFF_FFFF);
        rd(16'h8380, VFT_WORD_ZERO);
    endtask : t_regs
    task automatic t_prog();
        wr(VFT_OFS_TOTAL_ACTIVE, 32'h0009_0006);
        wr(VFT_OFS_BLANK_WIN, 32'h0009_0006 - SHIFT);
        wr(VFT_OFS_CRT_SYNC_WIN, 32'h0008_0007 - SHIFT);
        wr(VFT_OFS_PANEL_SYNC, 32'h0008_0007 - SHIFT);
        wr(VFT_OFS_CONTROL, 32'h0000_0002);
        lines(25, 1'b0);
        check("frame_lines", {21'h0, spf}, 32'hA);
        check("blank_lines", {21'h0, bsteps}, 32'h3);
        rd(VFT_OFS_LINE_COUNT, 32'h0000_0005);
    endtask : t_prog
    task automatic t_il();
        wr(VFT_OFS_CONTROL, VFT_WORD_ZERO);
        wr(VFT_OFS_TOTAL_ACTIVE, 32'h0008_0004);
        wr(VFT_OFS_BLANK_WIN, 32'h0008_0005);
        interlace <= 1'b1;
        wr(VFT_OFS_CONTROL, 32'h0000_0003);
        lines(12, 1'b1);
        check("field_steps", {21'h0, spf}, 32'h9);
        check("il_blank", {21'h0, bsteps}, 32'h4);
    endtask : t_il
    task automatic complete_run();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (2000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end
    initial begin
        {rst, clk_en, line_strobe, half_strobe, interlace} = 5'h18;
        bus_req = '0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_prog();
        t_il();
        complete_run();
    end
endmodule : vft_vertical_timing_tb
bind vft_vertical_timing vft_checker vft_checker_i (.core_clk(core_clk), .rst(rst),
    .clk_en(clk_en), .bus_req(bus_req), .rdata(rdata), .line_strobe(line_strobe),
    .half_strobe(half_strobe), .disp(disp), .line_count(line_count));
`default_nettype wire
